// ===== core/tc16_pkg.sv
// Package: register map, field layout and counts for the 16-bit timer
package tc16_pkg;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_GLOBAL_INT = 10'h00b;
	localparam logic [9:0] IDX_FLAGS      = 10'h00c;
	localparam logic [9:0] IDX_COUNT_LO   = 10'h00e;
	localparam logic [9:0] IDX_COUNT_HI   = 10'h00f;
	localparam logic [9:0] IDX_CONTROL    = 10'h010;
	localparam logic [9:0] IDX_ENABLES    = 10'h08c;

	// Field positions
	localparam int OVF_BIT = 0;

	// Reset values
	localparam logic [7:0] GLOBAL_INT_RST = 8'h00;
	localparam logic [7:0] CONTROL_RST    = 8'h00;
	localparam logic       FLAG_RST       = 1'b0;
	localparam logic       ENABLE_RST     = 1'b0;

	// Count limits
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [15:0] COUNT_CLR = 16'h0000;

	// Oscillator cycles per instruction cycle
	localparam int          OSC_PER_INSTR = 4;
	localparam logic [1:0]  INSTR_LAST    = 2'(OSC_PER_INSTR - 1);

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		PRE_DIV1,
		PRE_DIV2,
		PRE_DIV4,
		PRE_DIV8
	} prescale_t;

	typedef struct packed {
		logic [1:0] unused;
		prescale_t  prescale_field;
		logic       oscillator_enable;
		logic       sync_control;
		logic       clock_source_select;
		logic       run_control;
	} counter_control_t;

endpackage

// ===== core/timer16.sv
// Module: 16-bit timer/counter with AXI4-Lite register slave
// Behaviour
// - Count is a 16-bit pair of read/write high and low bytes.
// - Count rises from zero to all ones and wraps to zero.
// - Each wrap sets the sticky overflow flag, bit 0 of the flags.
// - Interrupt request raised only while overflow enable bit 0 is set.
// - Control bit 1 picks internal clock (0) or external pin (1).
// - Timer mode advances per instruction cycle, oscillator over four, after prescale.
// - Counter mode advances on external pin rising edges, after prescale.
// - Control bit 0 runs the count; zero holds it.
// - Special event trigger from capture/compare unit clears the pair.
// - Control bit 3 enables oscillator driver and feedback inverter.
// - With external clock, bit 2 set skips sync, clear synchronises.
// - Oscillator enabled forces both pins to input, reads return zero.
// - Control bits 7-6 read zero; other control bits reset to zero.
// - Count bytes undefined at power-on, unchanged by other resets.
`timescale 1ns/1ns
`default_nettype none

module timer16
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        special_event_trigger,
	input  wire logic        external_clock_pin,
	input  wire logic [1:0]  port_pin_in,
	input  wire logic [1:0]  port_direction_bits,
	input  wire logic [1:0]  port_latch,
	output var  logic [1:0]  port_pin_out,
	output var  logic [1:0]  port_pin_oe_n,
	output var  logic [1:0]  port_pin_read,
	output var  logic        osc_drive_enable,
	output var  logic        irq
);

	tc16_pkg::counter_control_t ctrl_r;
	logic [7:0]  global_int_r;
	logic        flag_r;
	logic        enable_r;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic [2:0]  pre_r;
	logic [2:0]  pre_nxt;
	logic [1:0]  instr_r;
	logic        ext_s1_r;
	logic        ext_s2_r;
	logic        ext_d_r;
	logic        ext_pend_r;
	logic [1:0]  pin_s1_r;
	logic [1:0]  pin_s2_r;
	logic        flag_nxt;

	// Write decode
	wire         wr_fire  = s_axi_awvalid & s_axi_awready;
	wire [9:0]   wr_idx   = s_axi_awaddr[11:2];
	wire         wr_lane  = wr_fire & s_axi_wstrb[0];
	wire [7:0]   wr_byte  = s_axi_wdata[7:0];
	wire         wr_gint  = wr_lane & (wr_idx == tc16_pkg::IDX_GLOBAL_INT);
	wire         wr_flags = wr_lane & (wr_idx == tc16_pkg::IDX_FLAGS);
	wire         wr_lo    = wr_lane & (wr_idx == tc16_pkg::IDX_COUNT_LO);
	wire         wr_hi    = wr_lane & (wr_idx == tc16_pkg::IDX_COUNT_HI);
	wire         wr_ctrl  = wr_lane & (wr_idx == tc16_pkg::IDX_CONTROL);
	wire         wr_en    = wr_lane & (wr_idx == tc16_pkg::IDX_ENABLES);
	wire         wr_hit   = (wr_idx == tc16_pkg::IDX_GLOBAL_INT)
		| (wr_idx == tc16_pkg::IDX_FLAGS)
		| (wr_idx == tc16_pkg::IDX_COUNT_LO)
		| (wr_idx == tc16_pkg::IDX_COUNT_HI)
		| (wr_idx == tc16_pkg::IDX_CONTROL)
		| (wr_idx == tc16_pkg::IDX_ENABLES);

	// Read decode
	wire [9:0]   rd_idx = s_axi_araddr[11:2];
	wire         rd_hit = (rd_idx == tc16_pkg::IDX_GLOBAL_INT)
		| (rd_idx == tc16_pkg::IDX_FLAGS)
		| (rd_idx == tc16_pkg::IDX_COUNT_LO)
		| (rd_idx == tc16_pkg::IDX_COUNT_HI)
		| (rd_idx == tc16_pkg::IDX_CONTROL)
		| (rd_idx == tc16_pkg::IDX_ENABLES);
	wire [7:0]   ctrl_rd = {2'b00, ctrl_r[5:0]};
	wire [7:0]   rd_byte =
		(rd_idx == tc16_pkg::IDX_GLOBAL_INT) ? global_int_r :
		(rd_idx == tc16_pkg::IDX_FLAGS)      ? {7'h00, flag_r} :
		(rd_idx == tc16_pkg::IDX_COUNT_LO)   ? count_r[7:0] :
		(rd_idx == tc16_pkg::IDX_COUNT_HI)   ? count_r[15:8] :
		(rd_idx == tc16_pkg::IDX_CONTROL)    ? ctrl_rd :
		(rd_idx == tc16_pkg::IDX_ENABLES)    ? {7'h00, enable_r} :
		8'h00;

	// Clock sources
	wire         instr_tick = (instr_r == tc16_pkg::INSTR_LAST);
	wire         ext_rise   = ext_s2_r & ~ext_d_r;
	wire         ext_sync   = (ext_pend_r | ext_rise) & instr_tick;
	wire         ext_event  = ctrl_r.sync_control ? ext_rise : ext_sync;
	wire         src_event  = ctrl_r.clock_source_select ? ext_event
		: instr_tick;
	wire [2:0]   pre_lim    =
		(ctrl_r.prescale_field == tc16_pkg::PRE_DIV8) ? 3'h7 :
		(ctrl_r.prescale_field == tc16_pkg::PRE_DIV4) ? 3'h3 :
		(ctrl_r.prescale_field == tc16_pkg::PRE_DIV2) ? 3'h1 :
		3'h0;
	wire         step      = ctrl_r.run_control & src_event;
	wire         inc       = step & (pre_r == pre_lim);
	wire         wrap      = inc & (count_r == tc16_pkg::COUNT_MAX);
	wire         cnt_wr    = wr_lo | wr_hi;

	always_comb
	begin
		pre_nxt = pre_r;
		if (step)
			pre_nxt = inc ? 3'h0 : pre_r + 3'h1;
		if (cnt_wr)
			pre_nxt = 3'h0;
	end

	always_comb
	begin
		count_nxt = count_r;
		if (inc)
			count_nxt = count_r + 16'h0001;
		if (wr_lo)
			count_nxt[7:0] = wr_byte;
		if (wr_hi)
			count_nxt[15:8] = wr_byte;
		if (special_event_trigger)
			count_nxt = tc16_pkg::COUNT_CLR;
	end

	// Set wins over a write-one clear
	always_comb
	begin
		flag_nxt = flag_r;
		if (wr_flags & wr_byte[tc16_pkg::OVF_BIT])
			flag_nxt = 1'b0;
		if (wrap)
			flag_nxt = 1'b1;
	end

	// Count pair has no reset
	always_ff @(posedge aclk)
	begin
		count_r <= count_nxt;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			instr_r    <= 2'b00;
			pre_r      <= 3'h0;
			ext_s1_r   <= 1'b0;
			ext_s2_r   <= 1'b0;
			ext_d_r    <= 1'b0;
			ext_pend_r <= 1'b0;
			pin_s1_r   <= 2'b00;
			pin_s2_r   <= 2'b00;
		end
		else
		begin
			instr_r    <= instr_r + 2'b01;
			pre_r      <= pre_nxt;
			ext_s1_r   <= external_clock_pin;
			ext_s2_r   <= ext_s1_r;
			ext_d_r    <= ext_s2_r;
			ext_pend_r <= (ext_pend_r | ext_rise) & ~instr_tick;
			pin_s1_r   <= port_pin_in;
			pin_s2_r   <= pin_s1_r;
		end
	end

	// Registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r       <= tc16_pkg::CONTROL_RST;
			global_int_r <= tc16_pkg::GLOBAL_INT_RST;
			flag_r       <= tc16_pkg::FLAG_RST;
			enable_r     <= tc16_pkg::ENABLE_RST;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= {2'b00, wr_byte[5:0]};
			if (wr_gint)
				global_int_r <= wr_byte;
			if (wr_en)
				enable_r <= wr_byte[tc16_pkg::OVF_BIT];
			flag_r <= flag_nxt;
		end
	end

	// Pins, oscillator and interrupt outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			port_pin_out     <= 2'b00;
			port_pin_oe_n    <= 2'b11;
			port_pin_read    <= 2'b00;
			osc_drive_enable <= 1'b0;
			irq              <= 1'b0;
		end
		else
		begin
			port_pin_out     <= port_latch;
			port_pin_oe_n    <= port_direction_bits
				| {2{ctrl_r.oscillator_enable}};
			port_pin_read    <= pin_s2_r
				& ~{2{ctrl_r.oscillator_enable}};
			osc_drive_enable <= ctrl_r.oscillator_enable;
			irq              <= flag_r & enable_r;
		end
	end

	// AXI4-Lite write channel: both address and data taken together
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= tc16_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
				& ~s_axi_bvalid;
			s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
				& ~s_axi_bvalid;
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? tc16_pkg::RESP_OKAY
					: tc16_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= tc16_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h000000, rd_byte};
				s_axi_rresp  <= rd_hit ? tc16_pkg::RESP_OKAY
					: tc16_pkg::RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Helper: count known once both bytes written or trigger seen
	logic lo_seen_r;
	logic hi_seen_r;
	wire  cnt_known = lo_seen_r & hi_seen_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lo_seen_r <= 1'b0;
			hi_seen_r <= 1'b0;
		end
		else
		begin
			lo_seen_r <= lo_seen_r | wr_lo | special_event_trigger;
			hi_seen_r <= hi_seen_r | wr_hi | special_event_trigger;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_wrap_to_zero: assert property (
		cnt_known && inc && count_r == 16'hffff && !cnt_wr
		&& !special_event_trigger |=> count_r == 16'h0000 && flag_r)
		else $error("count did not wrap to zero with flag");
	chk_flag_sticky: assert property (
		flag_r && !(wr_flags && wr_byte[0]) |=> flag_r)
		else $error("overflow flag dropped without clear");
	chk_irq_gate: assert property (
		##1 irq == $past(flag_r && enable_r))
		else $error("interrupt not gated by enable");
	chk_hold_stopped: assert property (
		cnt_known && !ctrl_r.run_control && !cnt_wr
		&& !special_event_trigger |=> $stable(count_r))
		else $error("count moved while stopped");
	chk_trigger_clear: assert property (
		special_event_trigger |=> count_r == 16'h0000)
		else $error("trigger did not clear count");
	chk_prescale_div: assert property (
		inc |-> step
		&& {1'b0, pre_r} == (4'h1 << ctrl_r.prescale_field) - 4'h1)
		else $error("increment before prescale period");
	chk_timer_rate: assert property (
		inc && !ctrl_r.clock_source_select |-> instr_tick)
		else $error("timer step off instruction cycle");
	chk_instr_period: assert property (
		instr_tick |=> !instr_tick [*3] ##1 instr_tick)
		else $error("instruction tick not every fourth clock");
	chk_osc_pins: assert property (
		ctrl_r.oscillator_enable |=> port_pin_oe_n == 2'b11
		&& port_pin_read == 2'b00)
		else $error("oscillator pins not forced to input");
	chk_ctrl_top: assert property (
		s_axi_arvalid && s_axi_arready
		&& rd_idx == tc16_pkg::IDX_CONTROL |=> s_axi_rdata[7:6] == 2'b00)
		else $error("control top bits not zero");
	chk_write_restart: assert property (
		cnt_wr |=> pre_r == 3'h0)
		else $error("count write did not restart prescaler");
	chk_osc_drive: assert property (
		##1 osc_drive_enable == $past(ctrl_r.oscillator_enable))
		else $error("oscillator drive does not follow enable");

	cov_wrap: cover property (wrap);
	cov_ext_async: cover property (inc && ctrl_r.clock_source_select
		&& ctrl_r.sync_control);
	cov_div8: cover property (inc
		&& ctrl_r.prescale_field == tc16_pkg::PRE_DIV8);
	cov_irq: cover property (irq);

endmodule

`default_nettype wire

// ===== dv/ext_clock_source.sv
// External clock source and crystal pins facing the timer
`timescale 1ns/1ns
`default_nettype none

module ext_clock_source
(
	output var logic       clk_pin,
	output var logic [1:0] osc_pins
);
	initial
	begin
		clk_pin = 1'b0;
		osc_pins = 2'b11;
	end

	// Bursts of clean edges, line low between bursts
	task automatic pulses(input int n);
		repeat (n)
		begin
			#330 clk_pin = 1'b1;
			#330 clk_pin = 1'b0;
		end
	endtask
endmodule

`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the 16-bit timer
`timescale 1ns/1ns
`default_nettype none

module tb;
	typedef struct packed {
		logic        rd;
		logic [1:0]  resp;
		logic [31:0] data;
	} note_t;

	logic        aclk;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [11:0] araddr = 12'h000;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        trig = 1'b0;
	logic [1:0]  dir = 2'b11;
	logic [1:0]  latch = 2'b00;
	logic        awready, wready, bvalid, arready, rvalid, irq, osc_en;
	logic        ext_pin;
	logic [1:0]  bresp, rresp, pin_out, oe_n, pin_rd, osc_pins;
	logic [31:0] rdata;
	logic [15:0] v;
	int          failures = 0;
	int          tests_run = 0;
	int          cnt;
	int          n;
	note_t       exp_q[$];
	note_t       nt;

	timer16 u_dut
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .special_event_trigger(trig),
		.external_clock_pin(ext_pin), .port_pin_in(osc_pins),
		.port_direction_bits(dir), .port_latch(latch),
		.port_pin_out(pin_out), .port_pin_oe_n(oe_n),
		.port_pin_read(pin_rd), .osc_drive_enable(osc_en), .irq(irq)
	);

	ext_clock_source u_src
	(
		.clk_pin(ext_pin),
		.osc_pins(osc_pins)
	);

	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic results;
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic wr(input logic [9:0] i, input logic [7:0] d,
		input logic [1:0] r = tc16_pkg::RESP_OKAY);
		logic a;
		logic w;
		@(posedge aclk);
		exp_q.push_back({1'b0, r, 32'h0});
		a = 1'b1;
		w = 1'b1;
		awaddr <= {i, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (a || w)
		begin
			@(posedge aclk);
			a = a && !awready;
			w = w && !wready;
			awvalid <= a;
			wvalid <= w;
		end
		do
			@(posedge aclk);
		while (!bvalid);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] i, input logic [7:0] d,
		input logic [1:0] r = tc16_pkg::RESP_OKAY);
		@(posedge aclk);
		exp_q.push_back({1'b1, r, 24'h0, d});
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge aclk);
		while (!arready);
		arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (!rvalid);
		rready <= 1'b0;
	endtask

	// Answer monitor: oldest note against each response
	always @(posedge aclk)
		if ((bvalid && bready) || (rvalid && rready))
		begin
			nt = exp_q.pop_front();
			check("resp", 32'(nt.resp), 32'(rvalid ? rresp : bresp));
			if (nt.rd)
				check("rdata", nt.data, rdata);
		end

	initial
	begin
		#3000000;
		failures++;
		results();
	end

	initial
	begin
		void'($urandom(74245));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(tc16_pkg::IDX_CONTROL, 8'h00);
		rd(tc16_pkg::IDX_FLAGS, 8'h00);
		rd(tc16_pkg::IDX_ENABLES, 8'h00);
		rd(10'h001, 8'h00, tc16_pkg::RESP_SLVERR);
		wr(10'h001, 8'h5a, tc16_pkg::RESP_SLVERR);
		v = 16'($urandom);
		wr(tc16_pkg::IDX_COUNT_HI, v[15:8]);
		wr(tc16_pkg::IDX_COUNT_LO, v[7:0]);
		rd(tc16_pkg::IDX_COUNT_HI, v[15:8]);
		rd(tc16_pkg::IDX_COUNT_LO, v[7:0]);
		trig <= 1'b1;
		@(posedge aclk);
		trig <= 1'b0;
		rd(tc16_pkg::IDX_COUNT_HI, 8'h00);
		rd(tc16_pkg::IDX_COUNT_LO, 8'h00);
		dir <= 2'($urandom);
		latch <= 2'($urandom);
		wr(tc16_pkg::IDX_CONTROL, 8'hff);
		rd(tc16_pkg::IDX_CONTROL, 8'h3f);
		check("osc", 32'h1, 32'(osc_en));
		check("oe_n", 32'h3, 32'(oe_n));
		check("pin read", 32'h0, 32'(pin_rd));
		wr(tc16_pkg::IDX_CONTROL, 8'h00);
		repeat (3) @(posedge aclk);
		check("osc", 32'h0, 32'(osc_en));
		check("oe_n", 32'(dir), 32'(oe_n));
		check("pin read", 32'h3, 32'(pin_rd));
		check("pin out", 32'(latch), 32'(pin_out));
		wr(tc16_pkg::IDX_ENABLES, 8'h01);
		for (int p = 0; p < 4; p++)
		begin
			wr(tc16_pkg::IDX_COUNT_HI, 8'hff);
			wr(tc16_pkg::IDX_COUNT_LO, 8'hff);
			wr(tc16_pkg::IDX_FLAGS, 8'h01);
			wr(tc16_pkg::IDX_CONTROL, {2'b00, 2'(p), 1'b0, p[0], 2'b01});
			cnt = 0;
			while (irq !== 1'b1 && cnt < 60)
			begin
				@(posedge aclk);
				cnt++;
			end
			n = 4 << p;
			check("irq delay", 32'h1, 32'(cnt >= n - 2 && cnt <= n + 1));
			wr(tc16_pkg::IDX_CONTROL, 8'h00);
		end
		wr(tc16_pkg::IDX_ENABLES, 8'h00);
		repeat (2) @(posedge aclk);
		check("irq masked", 32'h0, 32'(irq));
		rd(tc16_pkg::IDX_FLAGS, 8'h01);
		wr(tc16_pkg::IDX_FLAGS, 8'h01);
		rd(tc16_pkg::IDX_FLAGS, 8'h00);
		for (int s = 0; s < 2; s++)
		begin
			n = 1 + $urandom % 8;
			wr(tc16_pkg::IDX_COUNT_HI, 8'h00);
			wr(tc16_pkg::IDX_COUNT_LO, 8'h00);
			wr(tc16_pkg::IDX_CONTROL, {5'b00000, 1'(s), 2'b11});
			u_src.pulses(n);
			repeat (12) @(posedge aclk);
			wr(tc16_pkg::IDX_CONTROL, 8'h00);
			rd(tc16_pkg::IDX_COUNT_LO, 8'(n));
			rd(tc16_pkg::IDX_COUNT_HI, 8'h00);
		end
		wr(tc16_pkg::IDX_GLOBAL_INT, v[15:8]);
		rd(tc16_pkg::IDX_GLOBAL_INT, v[15:8]);
		wr(tc16_pkg::IDX_COUNT_HI, v[7:0]);
		wr(tc16_pkg::IDX_COUNT_LO, v[15:8]);
		wr(tc16_pkg::IDX_CONTROL, 8'h3e);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(tc16_pkg::IDX_GLOBAL_INT, tc16_pkg::GLOBAL_INT_RST);
		rd(tc16_pkg::IDX_CONTROL, tc16_pkg::CONTROL_RST);
		check("osc", 32'h0, 32'(osc_en));
		rd(tc16_pkg::IDX_COUNT_HI, v[7:0]);
		rd(tc16_pkg::IDX_COUNT_LO, v[15:8]);
		results();
	end
endmodule

`default_nettype wire
